// file: hdl/pnc_top.sv
/*
 * Memory function layer of a paged nonvolatile memory with write-cycle
 * counters, plus the read stream buffer it feeds.
 * Assumes a byte-level link layer that reports selection, reset pulses
 * and received bytes, and drains read bytes one per read slot group.
 */
// Notes on behaviour
// - Memory is 512 bytes in sixteen 32-byte pages, plus a 32-byte scratchpad.
// - Four write-cycle counters belong to pages twelve to fifteen, read only by A5H.
// - Target address arrives low byte first, then high byte.
// - Status byte holds accepted flag, a zero, partial flag, and ending offset.
// - Command A5H takes two address bytes, then returns memory from that address.
// - At each page end, counter, tamper bits and CRC follow in 80 slots.
// - Tamper bits read as the fixed pattern 55555555H.
// - After a trailer, the next page and its trailer follow, through the last page.
// - Pages without a counter return all ones in the counter field.
// - First page CRC covers command, address, data, counter and tamper bits.
// - Later page CRCs start cleared and cover only page data, counter, tamper.
// - After the last page trailer every read returns ones until reset.
// - A reset pulse abandons the counter read at any point.
// - Overdrive flag set means all memory function slots use overdrive timing.
// - A regular-speed reset returns the flag to regular speed.
// - Write scratchpad stores from the start offset and records ending offset.
// - Read scratchpad returns address, status, data, then ones.
// - Copy checks three authorization bytes, sets the accepted flag, then copies.
// - Write reaching offset 11111b returns inverted CRC16 on 16 read slots.
`timescale 1ns/1ns
`default_nettype none

module pnc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = AW'(DEPTH) == '0 ? (AW+1)'(DEPTH) : (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             rdy_q, rdy_d, vld_q, vld_d, push, pop;

    always_comb
    begin
        push  = i_in_valid && rdy_q;
        pop   = i_out_ready && vld_q;
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush)
        begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
        // Flags are registered from the next count so the ports stay glitch free.
        rdy_d = cnt_d != FULL;
        vld_d = cnt_d != '0;
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
        if (i_rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
            vld_q <= 1'b0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    assign o_in_ready  = rdy_q;
    assign o_out_valid = vld_q;
    assign o_out_data  = mem_q[rd_q];
endmodule

module pnc_top (
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_sel_ok,
    input  wire logic            i_bus_reset,
    input  wire logic            i_regular_reset,
    input  wire logic            i_od_set,
    input  wire pnc_pkg::pnc_rx_s i_rx,
    output logic                 o_tx_valid,
    output logic [7:0]           o_tx_data,
    input  wire logic            i_tx_ready,
    output logic                 o_overdrive_flag,
    output logic [7:0]           o_ending_offset_status,
    output logic                 o_copy_busy
);
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_CMD      = 4'h1,
        ST_ADDR_LO  = 4'h3,
        ST_ADDR_HI  = 4'h2,
        ST_WR_DATA  = 4'h6,
        ST_WR_CRC   = 4'h7,
        ST_RD_SP    = 4'h5,
        ST_CP_AUTH  = 4'h4,
        ST_COPY     = 4'hc,
        ST_CP_DONE  = 4'hd,
        ST_RD_MEM   = 4'hf,
        ST_RMC_DATA = 4'he,
        ST_RMC_TRL  = 4'ha,
        ST_ONES     = 4'hb
    } pnc_state_e;

    pnc_state_e  state_q, state_d;
    logic [7:0]  cmd_q, cmd_d;
    logic [15:0] ta_q, ta_d;
    logic [4:0]  end_q, end_d;
    logic        pf_q, pf_d, aa_q, aa_d, od_q, od_d;
    logic [15:0] crc_q, crc_d;
    logic [8:0]  idx_q, idx_d;
    logic [4:0]  sub_q, sub_d;
    logic [3:0]  trl_q, trl_d;

    logic [7:0]  mem_q [pnc_pkg::MEM_BYTES];
    logic [7:0]  sp_q  [pnc_pkg::SP_BYTES];
    logic [31:0] wcc_q [pnc_pkg::NUM_COUNTERS];

    logic        push, fifo_rdy, mem_we, sp_we, wcc_inc;
    logic [7:0]  push_data, es, trl_byte;
    logic [8:0]  copy_addr;
    logic [3:0]  trl_page;
    logic [31:0] trl_cnt;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ pnc_pkg::CRC_POLY_REFL) : (r >> 1);
        end
        return r;
    endfunction

    always_comb
    begin
        es = {aa_q, 1'b0, pf_q, end_q};
        // The trailer belongs to the page just finished; idx has already moved on.
        trl_page = 4'(idx_q[8:5] - 4'h1);
        trl_cnt  = (trl_page[3:2] == pnc_pkg::COUNTER_PAGE_HI) ? wcc_q[trl_page[1:0]]
                                                               : pnc_pkg::NO_COUNTER;
        if (trl_q <= pnc_pkg::TRAILER_CNT_END)
        begin
            trl_byte = trl_cnt[trl_q[1:0]*8 +: 8];
        end
        else if (trl_q <= pnc_pkg::TRAILER_TMP_END)
        begin
            trl_byte = pnc_pkg::TAMPER_PATTERN[trl_q[1:0]*8 +: 8];
        end
        else
        begin
            trl_byte = trl_q[0] ? ~crc_q[15:8] : ~crc_q[7:0];
        end
        copy_addr = {ta_q[8:5], sub_q};
    end

    always_comb
    begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        ta_d      = ta_q;
        end_d     = end_q;
        pf_d      = pf_q;
        aa_d      = aa_q;
        od_d      = od_q;
        crc_d     = crc_q;
        idx_d     = idx_q;
        sub_d     = sub_q;
        trl_d     = trl_q;
        push      = 1'b0;
        push_data = pnc_pkg::BYTE_ONES;
        mem_we    = 1'b0;
        sp_we     = 1'b0;
        wcc_inc   = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (i_sel_ok)
                begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD:
            begin
                if (i_rx.valid)
                begin
                    cmd_d = i_rx.data;
                    crc_d = crc_byte(pnc_pkg::CRC_CLEAR, i_rx.data);
                    idx_d = '0;
                    sub_d = ta_q[4:0];
                    if (i_rx.data == pnc_pkg::CMD_READ_SP)
                    begin
                        state_d = ST_RD_SP;
                    end
                    else if (i_rx.data == pnc_pkg::CMD_COPY_SP)
                    begin
                        state_d = ST_CP_AUTH;
                    end
                    else if (i_rx.data == pnc_pkg::CMD_WRITE_SP ||
                             i_rx.data == pnc_pkg::CMD_READ_MEM ||
                             i_rx.data == pnc_pkg::CMD_READ_MEM_CNT)
                    begin
                        state_d = ST_ADDR_LO;
                    end
                    else
                    begin
                        state_d = ST_ONES;
                    end
                end
            end
            ST_ADDR_LO:
            begin
                if (i_rx.valid)
                begin
                    ta_d[7:0] = i_rx.data;
                    crc_d     = crc_byte(crc_q, i_rx.data);
                    state_d   = ST_ADDR_HI;
                end
            end
            ST_ADDR_HI:
            begin
                if (i_rx.valid)
                begin
                    // Addresses above the map lose their top seven bits as they land.
                    ta_d[15:8] = {7'h00, i_rx.data[0]};
                    crc_d      = crc_byte(crc_q, i_rx.data);
                    idx_d      = {i_rx.data[0], ta_q[7:0]};
                    sub_d      = ta_q[4:0];
                    if (cmd_q == pnc_pkg::CMD_WRITE_SP)
                    begin
                        end_d   = ta_q[4:0];
                        pf_d    = 1'b0;
                        aa_d    = 1'b0;
                        state_d = ST_WR_DATA;
                    end
                    else if (cmd_q == pnc_pkg::CMD_READ_MEM)
                    begin
                        state_d = ST_RD_MEM;
                    end
                    else
                    begin
                        state_d = ST_RMC_DATA;
                    end
                end
            end
            ST_WR_DATA:
            begin
                if (i_rx.partial)
                begin
                    pf_d = 1'b1;
                end
                if (i_rx.valid)
                begin
                    sp_we = 1'b1;
                    end_d = sub_q;
                    crc_d = crc_byte(crc_q, i_rx.data);
                    sub_d = 5'(sub_q + 5'h01);
                    if (sub_q == pnc_pkg::PAGE_LAST_OFS)
                    begin
                        trl_d   = pnc_pkg::TRAILER_LAST - 4'h1;
                        state_d = ST_WR_CRC;
                    end
                end
            end
            ST_WR_CRC:
            begin
                if (fifo_rdy)
                begin
                    push      = 1'b1;
                    push_data = trl_byte;
                    trl_d     = 4'(trl_q + 4'h1);
                    if (trl_q == pnc_pkg::TRAILER_LAST)
                    begin
                        state_d = ST_ONES;
                    end
                end
            end
            ST_RD_SP:
            begin
                if (fifo_rdy)
                begin
                    push  = 1'b1;
                    idx_d = 9'(idx_q + 9'h001);
                    unique case (idx_q[1:0])
                        2'h0: push_data = ta_q[7:0];
                        2'h1: push_data = ta_q[15:8];
                        2'h2: push_data = es;
                        2'h3:
                        begin
                            push_data = sp_q[sub_q];
                            idx_d     = idx_q;
                            sub_d     = 5'(sub_q + 5'h01);
                            if (sub_q == pnc_pkg::PAGE_LAST_OFS)
                            begin
                                state_d = ST_ONES;
                            end
                        end
                    endcase
                end
            end
            ST_CP_AUTH:
            begin
                if (i_rx.valid)
                begin
                    idx_d = 9'(idx_q + 9'h001);
                    if (i_rx.data != (idx_q[1:0] == 2'h0 ? ta_q[7:0] :
                                      idx_q[1:0] == 2'h1 ? ta_q[15:8] : es))
                    begin
                        state_d = ST_ONES;
                    end
                    else if (idx_q[1:0] == 2'h2)
                    begin
                        aa_d    = 1'b1;
                        state_d = ST_COPY;
                    end
                end
            end
            ST_COPY:
            begin
                mem_we = 1'b1;
                sub_d  = 5'(sub_q + 5'h01);
                if (sub_q == end_q)
                begin
                    wcc_inc = ta_q[8:7] == pnc_pkg::COUNTER_PAGE_HI;
                    state_d = ST_CP_DONE;
                end
            end
            ST_CP_DONE:
            begin
                push      = fifo_rdy;
                push_data = pnc_pkg::BYTE_ALT;
            end
            ST_RD_MEM:
            begin
                if (fifo_rdy)
                begin
                    push      = 1'b1;
                    push_data = mem_q[idx_q];
                    idx_d     = 9'(idx_q + 9'h001);
                    if (idx_q == pnc_pkg::MEM_LAST_ADDR)
                    begin
                        state_d = ST_ONES;
                    end
                end
            end
            ST_RMC_DATA:
            begin
                if (fifo_rdy)
                begin
                    push      = 1'b1;
                    push_data = mem_q[idx_q];
                    crc_d     = crc_byte(crc_q, mem_q[idx_q]);
                    idx_d     = 9'(idx_q + 9'h001);
                    if (idx_q[4:0] == pnc_pkg::PAGE_LAST_OFS)
                    begin
                        trl_d   = '0;
                        state_d = ST_RMC_TRL;
                    end
                end
            end
            ST_RMC_TRL:
            begin
                if (fifo_rdy)
                begin
                    push      = 1'b1;
                    push_data = trl_byte;
                    trl_d     = 4'(trl_q + 4'h1);
                    if (trl_q <= pnc_pkg::TRAILER_TMP_END)
                    begin
                        crc_d = crc_byte(crc_q, trl_byte);
                    end
                    if (trl_q == pnc_pkg::TRAILER_LAST)
                    begin
                        crc_d   = pnc_pkg::CRC_CLEAR;
                        // A wrapped index means page fifteen has just closed.
                        state_d = (idx_q == '0) ? ST_ONES : ST_RMC_DATA;
                    end
                end
            end
            ST_ONES:
            begin
                push      = fifo_rdy;
                push_data = pnc_pkg::BYTE_ONES;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        // A copy in progress runs to completion; reset pulses do not abort it then.
        if (i_bus_reset && state_q != ST_COPY)
        begin
            state_d = ST_IDLE;
        end
        if (i_regular_reset)
        begin
            od_d = 1'b0;
        end
        if (i_od_set)
        begin
            od_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (sp_we)
        begin
            sp_q[sub_q] <= i_rx.data;
        end
        if (mem_we)
        begin
            mem_q[copy_addr] <= sp_q[sub_q];
        end
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            cmd_q   <= '0;
            ta_q    <= '0;
            end_q   <= '0;
            pf_q    <= 1'b0;
            aa_q    <= 1'b0;
            od_q    <= 1'b0;
            crc_q   <= pnc_pkg::CRC_CLEAR;
            idx_q   <= '0;
            sub_q   <= '0;
            trl_q   <= '0;
            for (int i = 0; i < pnc_pkg::NUM_COUNTERS; i++)
            begin
                wcc_q[i] <= '0;
            end
            o_overdrive_flag       <= 1'b0;
            o_ending_offset_status <= '0;
            o_copy_busy            <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            ta_q    <= ta_d;
            end_q   <= end_d;
            pf_q    <= pf_d;
            aa_q    <= aa_d;
            od_q    <= od_d;
            crc_q   <= crc_d;
            idx_q   <= idx_d;
            sub_q   <= sub_d;
            trl_q   <= trl_d;
            // Counters saturate rather than roll over.
            if (wcc_inc && wcc_q[ta_q[6:5]] != pnc_pkg::NO_COUNTER)
            begin
                wcc_q[ta_q[6:5]] <= wcc_q[ta_q[6:5]] + 32'h00000001;
            end
            o_overdrive_flag       <= od_d;
            o_ending_offset_status <= {aa_d, 1'b0, pf_d, end_d};
            o_copy_busy            <= state_d == ST_COPY;
        end
    end

    pnc_fifo #(
        .WIDTH(pnc_pkg::BYTE_W),
        .DEPTH(pnc_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_flush    (i_bus_reset && state_q != ST_COPY),
        .i_in_valid (push),
        .i_in_data  (push_data),
        .o_in_ready (fifo_rdy),
        .o_out_valid(o_tx_valid),
        .o_out_data (o_tx_data),
        .i_out_ready(i_tx_ready)
    );
endmodule

`default_nettype wire

// file: include/pnc_pkg.sv
/*
 * Shared constants and carrier types for the paged nonvolatile memory
 * counter reader: command codes, map geometry, status field layout and
 * the trailer layout of the read-with-counter stream.
 * Assumes a byte-level link layer outside that handles slots and presence.
 */
`default_nettype none

package pnc_pkg;

    // Memory function command codes.
    localparam logic [7:0] CMD_WRITE_SP    = 8'h0f;
    localparam logic [7:0] CMD_READ_SP     = 8'haa;
    localparam logic [7:0] CMD_COPY_SP     = 8'h5a;
    localparam logic [7:0] CMD_READ_MEM    = 8'hf0;
    localparam logic [7:0] CMD_READ_MEM_CNT = 8'ha5;

    // Memory geometry: 512 bytes in sixteen pages of 32 bytes.
    localparam int         MEM_BYTES      = 512;
    localparam int         SP_BYTES       = 32;
    localparam int         NUM_COUNTERS   = 4;
    localparam logic [8:0] MEM_LAST_ADDR  = 9'h1ff;
    localparam logic [4:0] PAGE_LAST_OFS  = 5'h1f;
    localparam logic [1:0] COUNTER_PAGE_HI = 2'h3;

    // Fixed data in the counter trailer.
    localparam logic [31:0] TAMPER_PATTERN = 32'h55555555;
    localparam logic [31:0] NO_COUNTER     = 32'hffffffff;
    localparam logic [3:0]  TRAILER_CNT_END = 4'h3;
    localparam logic [3:0]  TRAILER_TMP_END = 4'h7;
    localparam logic [3:0]  TRAILER_LAST    = 4'h9;

    // Fill bytes.
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ALT  = 8'haa;

    // CRC16, reflected form of x16+x15+x2+1.
    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
    localparam logic [15:0] CRC_CLEAR     = 16'h0000;

    // Ending offset and status register layout.
    localparam int ES_AA_BIT  = 7;
    localparam int ES_ZERO_BIT = 6;
    localparam int ES_PF_BIT  = 5;

    // Read stream buffer.
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W     = 8;

    // One byte from the link layer, or the end of an incomplete byte.
    typedef struct packed {
        logic       valid;
        logic       partial;
        logic [7:0] data;
    } pnc_rx_s;

endpackage

`default_nettype wire

// file: verif/pnc_checker.sv
/* Port assertions for pnc_top. Assumes the bench pulses a link reset before each selection. */
`timescale 1ns/1ns
`default_nettype none
module pnc_checker (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_sel_ok,
    input  wire logic             i_bus_reset,
    input  wire logic             i_regular_reset,
    input  wire logic             i_od_set,
    input  wire pnc_pkg::pnc_rx_s i_rx,
    input  wire logic             o_tx_valid,
    input  wire logic [7:0]       o_tx_data,
    input  wire logic             i_tx_ready,
    input  wire logic             o_overdrive_flag,
    input  wire logic [7:0]       o_ending_offset_status,
    input  wire logic             o_copy_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_a5_open;
        i_sel_ok ##1 (i_rx.valid && i_rx.data == 8'ha5) ##1 i_rx.valid ##1 i_rx.valid;
    endsequence
    property p_a5_answer; s_a5_open |-> ##2 o_tx_valid; endproperty
    a_a5_answer: assert property (p_a5_answer) else $error("read data late");
    property p_od_set; i_od_set |=> o_overdrive_flag; endproperty
    a_od_set: assert property (p_od_set) else $error("overdrive not set");
    property p_od_clr; i_regular_reset && !i_od_set |=> !o_overdrive_flag; endproperty
    a_od_clr: assert property (p_od_clr) else $error("overdrive not cleared");
    property p_od_hold; !i_od_set && !i_regular_reset |=> $stable(o_overdrive_flag); endproperty
    a_od_hold: assert property (p_od_hold) else $error("overdrive changed");
    property p_es_zero; !o_ending_offset_status[6]; endproperty
    a_es_zero: assert property (p_es_zero) else $error("status bit 6 set");
    property p_stall; o_tx_valid && !i_tx_ready && !i_bus_reset
        |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    a_stall: assert property (p_stall) else $error("stalled byte lost");
    property p_flush; i_bus_reset && !o_copy_busy |=> !o_tx_valid; endproperty
    a_flush: assert property (p_flush) else $error("abort left data");
    property p_copy_flag; $rose(o_copy_busy) |-> ##[0:2] o_ending_offset_status[7]; endproperty
    a_copy_flag: assert property (p_copy_flag) else $error("copy without flag");
endmodule
bind pnc_top pnc_checker u_chk (.*);
`default_nettype wire

// file: verif/pnc_master.sv
/* Byte-level model of the bus master. Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ns
`default_nettype none
module pnc_master (
    input  wire logic            i_clk,
    input  wire logic            i_tx_valid,
    input  wire logic [7:0]      i_tx_data,
    output var logic             o_sel_ok,
    output var logic             o_bus_reset,
    output var logic             o_regular_reset,
    output var logic             o_tx_ready,
    output var pnc_pkg::pnc_rx_s o_rx
);
    logic [7:0] rxq[$];
    initial
    begin
        o_sel_ok = 1'h0;
        o_bus_reset = 1'h0;
        o_regular_reset = 1'h0;
        o_tx_ready = 1'h0;
        o_rx = '0;
    end
    task automatic send(input logic [7:0] b[$], input bit sel, input bit part);
        @(negedge i_clk);
        o_sel_ok = sel;
        foreach (b[i])
        begin
            @(negedge i_clk);
            o_sel_ok = 1'h0;
            o_rx = '{1'h1, 1'h0, b[i]};
        end
        @(negedge i_clk);
        // Idle data is scrambled so that stale bytes cannot pass for fresh ones.
        o_rx = '{1'h0, part, ~o_rx.data};
        @(negedge i_clk);
        o_rx.partial = 1'h0;
    endtask
    task automatic get(input int n, input bit slow);
        int k = 0;
        rxq.delete();
        while (rxq.size() < n)
        begin
            @(negedge i_clk);
            o_tx_ready = !slow || k[1];
            k++;
            @(posedge i_clk);
            if (i_tx_valid && o_tx_ready)
                rxq.push_back(i_tx_data);
        end
        @(negedge i_clk);
        o_tx_ready = 1'h0;
    endtask
    task automatic pulse_reset(input bit regular);
        @(negedge i_clk);
        o_bus_reset = 1'h1;
        o_regular_reset = regular;
        @(negedge i_clk);
        o_bus_reset = 1'h0;
        o_regular_reset = 1'h0;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_paged_nvram_counter_reader.sv
/* Self-checking bench for pnc_top. Assumes the package, design, model and checker come first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h, expected %h", $time, (a), (e)); end end
module tb_paged_nvram_counter_reader;
    logic             clk = 1'h0;
    logic             rst = 1'h1;
    logic             od_set = 1'h0;
    logic             tx_valid, od, busy, sel, brst, rreg, ready;
    logic [7:0]       tx_data, es;
    pnc_pkg::pnc_rx_s rx;
    int               errors = 0;
    int               check_count = 0;
    int               cyc = 0;
    logic [7:0]       e[$];
    always #10 clk = ~clk;
    pnc_master u_m (.i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_sel_ok(sel),
        .o_bus_reset(brst), .o_regular_reset(rreg), .o_tx_ready(ready), .o_rx(rx));
    pnc_top DUT (.i_clk(clk), .i_rst(rst), .i_sel_ok(sel), .i_bus_reset(brst),
        .i_regular_reset(rreg), .i_od_set(od_set), .i_rx(rx), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_tx_ready(ready), .o_overdrive_flag(od),
        .o_ending_offset_status(es), .o_copy_busy(busy));
    task automatic cmp(input int s);
        foreach (e[i])
            if (i >= s)
                `CHK(u_m.rxq[i - s], e[i])
    endtask
    task automatic data32();
        for (int k = 0; k < 32; k++)
            e.push_back(8'h40 + k[7:0]);
    endtask
    task automatic tr(input logic [31:0] c);
        for (int k = 0; k < 4; k++)
            e.push_back(c[8*k +: 8]);
        repeat (4) e.push_back(8'h55);
    endtask
    // Reflected generator, cleared first; the result goes out inverted, low byte first.
    task automatic crc(input int from);
        logic [15:0] c = 16'h0000;
        for (int k = from; k < e.size(); k++)
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ e[k][b]) ? (c >> 1) ^ 16'ha001 : c >> 1;
        e.push_back(~c[7:0]);
        e.push_back(~c[15:8]);
    endtask
    task automatic t_write();
        e = '{8'h0f, 8'h80, 8'h03};
        data32();
        u_m.send(e, 1'h1, 1'h0);
        crc(0);
        e.push_back(8'hff);
        u_m.get(3, 1'h0);
        `CHK(es, 8'h1f)
        cmp(35);
        u_m.pulse_reset(1'h0);
        u_m.send('{8'haa}, 1'h1, 1'h0);
        u_m.get(36, 1'h0);
        e = '{8'h80, 8'h01, 8'h1f};
        data32();
        e.push_back(8'hff);
        cmp(0);
        $display("write and read back done");
    endtask
    task automatic t_copy();
        int n = 0;
        u_m.pulse_reset(1'h0);
        fork
            u_m.send('{8'h5a, 8'h80, 8'h01, 8'h1f}, 1'h1, 1'h0);
            repeat (120) @(negedge clk) n += int'(busy === 1'h1);
        join
        `CHK(n, 32)
        `CHK(es, 8'h9f)
        u_m.get(2, 1'h0);
        e = '{8'haa, 8'haa};
        cmp(0);
        u_m.pulse_reset(1'h0);
        u_m.send('{8'hf0, 8'h9e, 8'h01}, 1'h1, 1'h0);
        u_m.get(2, 1'h0);
        e = '{8'h5e, 8'h5f};
        cmp(0);
        $display("copy done");
    endtask
    task automatic t_counter();
        u_m.pulse_reset(1'h0);
        u_m.send('{8'h0f, 8'h7f, 8'h01, 8'h3c}, 1'h1, 1'h0);
        u_m.pulse_reset(1'h0);
        u_m.send('{8'h5a, 8'h7f, 8'h01, 8'h1f}, 1'h1, 1'h0);
        repeat (10) @(negedge clk);
        u_m.pulse_reset(1'h0);
        u_m.send('{8'ha5, 8'h7f, 8'h01}, 1'h1, 1'h0);
        u_m.get(53, 1'h1);
        e = '{8'ha5, 8'h7f, 8'h01, 8'h3c};
        tr(32'hffffffff);
        crc(0);
        data32();
        tr(32'h00000001);
        crc(14);
        cmp(3);
        u_m.pulse_reset(1'h0);
        @(negedge clk);
        `CHK(tx_valid, 1'h0)
        u_m.send('{8'ha5, 8'hff, 8'h01}, 1'h1, 1'h0);
        u_m.get(13, 1'h0);
        e = '{};
        tr(32'h00000000);
        for (int k = 0; k < 8; k++)
            `CHK(u_m.rxq[k + 1], e[k])
        `CHK({u_m.rxq[11], u_m.rxq[12]}, 16'hffff)
        $display("counter read done");
    endtask
    task automatic t_misc();
        u_m.pulse_reset(1'h0);
        u_m.send('{8'ha5, 8'h00, 8'h00}, 1'h0, 1'h0);
        repeat (4) @(negedge clk);
        `CHK(tx_valid, 1'h0)
        u_m.send('{8'h33}, 1'h1, 1'h0);
        u_m.get(2, 1'h0);
        e = '{8'hff, 8'hff};
        cmp(0);
        u_m.pulse_reset(1'h0);
        u_m.send('{8'h0f, 8'h26, 8'h00, 8'h11, 8'h22}, 1'h1, 1'h1);
        `CHK(es, 8'h27)
        od_set = 1'h1;
        @(negedge clk);
        od_set = 1'h0;
        u_m.pulse_reset(1'h0);
        `CHK(od, 1'h1)
        u_m.pulse_reset(1'h1);
        `CHK(od, 1'h0)
        $display("misc done");
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        `CHK({tx_valid, od, busy, es}, 11'h000)
        t_write();
        t_copy();
        t_counter();
        t_misc();
        test_done();
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            test_done();
        end
    end
endmodule
`default_nettype wire
